/* rtl/slope_adc_pkg.sv */
// Purpose: Constants and types for the slope converter timer and capture block
// Assumes: Registers are eight bits wide, one per 32-bit Avalon word
// Notes: Byte address of a register is four times its index
package slope_adc_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CPU_IRQ_CTL = 8'h0B;
  localparam logic [7:0] IDX_PERIPH_FLAG = 8'h0C;
  localparam logic [7:0] IDX_TIMER_LOW = 8'h0E;
  localparam logic [7:0] IDX_TIMER_HIGH = 8'h0F;
  localparam logic [7:0] IDX_CAPTURE_LOW = 8'h15;
  localparam logic [7:0] IDX_CAPTURE_HIGH = 8'h16;
  localparam logic [7:0] IDX_SLEEP_CTL = 8'h1D;
  localparam logic [7:0] IDX_CONV_CTL0 = 8'h1F;
  localparam logic [7:0] IDX_PERIPH_ENABLE = 8'h8C;
  localparam logic [7:0] IDX_CONV_CTL1 = 8'h9F;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_EN = 6;
  localparam int BIT_CAPTURE = 1;
  localparam int BIT_ROLLOVER = 0;
  localparam int BIT_REF_PD = 5;
  localparam int BIT_CONV_PD = 0;
  localparam int BIT_RAMP_RESET = 1;
  localparam logic [7:0] CTL0_MASK = 8'hF7;
  localparam logic [7:0] CTL0_RESET = 8'h02;
  localparam logic [7:0] CTL1_RESET = 8'h00;
  localparam logic [7:0] SLEEP_MASK = 8'h21;
  localparam logic [7:0] SLEEP_RESET = 8'h21;
  localparam logic [7:0] FLAG_MASK = 8'h03;
  localparam logic [7:0] IRQ_CTL_MASK = 8'hC0;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [15:0] TIMER_MAX = 16'hFFFF;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam int RAMP_DISCHARGE_US = 200;
  localparam int CLK_MHZ = 250;
  localparam int RAMP_DISCHARGE_CYC = RAMP_DISCHARGE_US * CLK_MHZ;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_type;

  typedef struct packed {
    logic [3:0] channel_sel;
    logic [3:0] current_sel;
    logic ramp_discharge;
    logic current_enable;
    logic reference_power_down;
    logic converter_power_down;
  } analog_ctl_type;
endpackage : slope_adc_pkg

/* rtl/slope_adc_timer_capture.sv */
// Purpose: Timer, capture and register slave of a slope converter
// Assumes: i_ref_clk is the chosen conversion oscillator; i_ramp_cmp is asynchronous
// Notes: Every access takes one wait cycle; unmapped reads return zero
`timescale 1ns/1ps
module slope_adc_timer_capture (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire slope_adc_pkg::avmm_req_type i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_ramp_cmp,
  output slope_adc_pkg::analog_ctl_type o_analog,
  output logic o_irq
);

  logic ack;
  logic req;
  logic wr_commit;
  logic reg_hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [15:0] ramp_count_timer;
  logic [15:0] capture_value;
  logic [7:0] converter_ctl0;
  logic [7:0] converter_ctl1;
  logic [7:0] sleep_ctl_reg;
  logic [7:0] periph_enable_reg;
  logic [7:0] cpu_irq_ctl_reg;
  logic capture_flag;
  logic rollover_flag;
  logic high_pending;
  logic timer_armed;
  logic capture_done;
  logic cmp_s1;
  logic cmp_s2;
  logic cmp_s3;
  logic cmp_level;
  logic cmp_fall;
  logic cap_strobe;
  logic ramp_reset_ctl;
  logic powered;
  logic running;
  logic wr_tmr_low;
  logic wr_tmr_high;
  logic wr_cap_low;
  logic wr_cap_high;
  logic wr_flag;
  logic tmr_wr;
  logic next_irq;
  logic [7:0] next_rdata;

  // Bus decode: one wait cycle, then the access completes
  assign req = i_avs.read | i_avs.write;
  assign o_avs_waitrequest = req & ~ack;
  assign idx = i_avs.address[9:2];
  assign reg_hit = (i_avs.address[1:0] == 2'h0);
  assign wr_commit = i_avs.write & ack & i_avs.byteenable[0] & reg_hit;
  assign wbyte = i_avs.writedata[7:0];
  assign wr_tmr_low = wr_commit & (idx == slope_adc_pkg::IDX_TIMER_LOW);
  assign wr_tmr_high = wr_commit & (idx == slope_adc_pkg::IDX_TIMER_HIGH);
  assign wr_cap_low = wr_commit & (idx == slope_adc_pkg::IDX_CAPTURE_LOW);
  assign wr_cap_high = wr_commit & (idx == slope_adc_pkg::IDX_CAPTURE_HIGH);
  assign wr_flag = wr_commit & (idx == slope_adc_pkg::IDX_PERIPH_FLAG);
  assign tmr_wr = wr_tmr_low | wr_tmr_high;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_hit) begin
      case (idx)
        slope_adc_pkg::IDX_TIMER_LOW: next_rdata = ramp_count_timer[7:0];
        slope_adc_pkg::IDX_TIMER_HIGH: next_rdata = ramp_count_timer[15:8];
        slope_adc_pkg::IDX_CAPTURE_LOW: next_rdata = capture_value[7:0];
        slope_adc_pkg::IDX_CAPTURE_HIGH: next_rdata = capture_value[15:8];
        slope_adc_pkg::IDX_PERIPH_FLAG: begin
          next_rdata[slope_adc_pkg::BIT_CAPTURE] = capture_flag;
          next_rdata[slope_adc_pkg::BIT_ROLLOVER] = rollover_flag;
        end
        slope_adc_pkg::IDX_PERIPH_ENABLE: next_rdata = periph_enable_reg;
        slope_adc_pkg::IDX_CPU_IRQ_CTL: next_rdata = cpu_irq_ctl_reg;
        slope_adc_pkg::IDX_SLEEP_CTL: next_rdata = sleep_ctl_reg;
        slope_adc_pkg::IDX_CONV_CTL0: next_rdata = converter_ctl0;
        slope_adc_pkg::IDX_CONV_CTL1: next_rdata = converter_ctl1;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs.read & ~ack) begin
      o_avs_readdata <= {24'h000000, next_rdata};
    end
  end

  // Control registers; reserved bits are masked so they read as zero
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      converter_ctl0 <= slope_adc_pkg::CTL0_RESET;
      converter_ctl1 <= slope_adc_pkg::CTL1_RESET;
      sleep_ctl_reg <= slope_adc_pkg::SLEEP_RESET;
      periph_enable_reg <= 8'h00;
      cpu_irq_ctl_reg <= 8'h00;
    end else if (wr_commit) begin
      case (idx)
        slope_adc_pkg::IDX_CONV_CTL0: converter_ctl0 <= wbyte & slope_adc_pkg::CTL0_MASK;
        slope_adc_pkg::IDX_CONV_CTL1: converter_ctl1 <= wbyte;
        slope_adc_pkg::IDX_SLEEP_CTL: sleep_ctl_reg <= wbyte & slope_adc_pkg::SLEEP_MASK;
        slope_adc_pkg::IDX_PERIPH_ENABLE: periph_enable_reg <= wbyte & slope_adc_pkg::FLAG_MASK;
        slope_adc_pkg::IDX_CPU_IRQ_CTL: cpu_irq_ctl_reg <= wbyte & slope_adc_pkg::IRQ_CTL_MASK;
        default: begin
        end
      endcase
    end
  end

  assign ramp_reset_ctl = converter_ctl0[slope_adc_pkg::BIT_RAMP_RESET];
  assign powered = ~sleep_ctl_reg[slope_adc_pkg::BIT_REF_PD] & ~sleep_ctl_reg[slope_adc_pkg::BIT_CONV_PD];
  assign running = powered & ~ramp_reset_ctl & timer_armed;

  // Analog side controls; the current source stays off while discharging
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_analog <= '0;
    end else begin
      o_analog.channel_sel <= converter_ctl0[7:4];
      o_analog.current_sel <= converter_ctl1[7:4];
      o_analog.ramp_discharge <= ramp_reset_ctl;
      o_analog.current_enable <= powered & ~ramp_reset_ctl;
      o_analog.reference_power_down <= sleep_ctl_reg[slope_adc_pkg::BIT_REF_PD];
      o_analog.converter_power_down <= sleep_ctl_reg[slope_adc_pkg::BIT_CONV_PD];
    end
  end

  // A low byte written without a fresh high byte leaves the timer stopped
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      high_pending <= 1'b0;
      timer_armed <= 1'b1;
    end else if (wr_tmr_high) begin
      high_pending <= 1'b1;
    end else if (wr_tmr_low) begin
      high_pending <= 1'b0;
      timer_armed <= high_pending;
    end
  end

  // Clock source selection happens ahead of i_ref_clk, so either oscillator works
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ramp_count_timer <= slope_adc_pkg::TIMER_RESET;
    end else if (wr_tmr_high) begin
      ramp_count_timer[15:8] <= wbyte;
    end else if (wr_tmr_low) begin
      ramp_count_timer[7:0] <= wbyte;
    end else if (running) begin
      ramp_count_timer <= ramp_count_timer + 16'h0001;
    end
  end

  // Comparator synchroniser; a level counts once the second and third stages agree
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_level <= 1'b0;
    end else begin
      cmp_s1 <= i_ramp_cmp;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3) begin
        cmp_level <= cmp_s3;
      end
    end
  end

  assign cmp_fall = cmp_level & ~cmp_s2 & ~cmp_s3;
  assign cap_strobe = cmp_fall & ~capture_done & ~ramp_reset_ctl & powered;

  // A new conversion cycle begins with the ramp reset, which re-arms capture
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      capture_done <= 1'b0;
    end else if (ramp_reset_ctl) begin
      capture_done <= 1'b0;
    end else if (cap_strobe) begin
      capture_done <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      capture_value <= slope_adc_pkg::CAPTURE_RESET;
    end else if (wr_cap_high) begin
      capture_value[15:8] <= wbyte;
    end else if (wr_cap_low) begin
      capture_value[7:0] <= wbyte;
    end else if (cap_strobe) begin
      capture_value <= ramp_count_timer;
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      capture_flag <= 1'b0;
      rollover_flag <= 1'b0;
    end else begin
      if (cap_strobe) begin
        capture_flag <= 1'b1;
      end else if (wr_flag) begin
        capture_flag <= wbyte[slope_adc_pkg::BIT_CAPTURE];
      end
      if (running && !tmr_wr && ramp_count_timer == slope_adc_pkg::TIMER_MAX) begin
        rollover_flag <= 1'b1;
      end else if (wr_flag) begin
        rollover_flag <= wbyte[slope_adc_pkg::BIT_ROLLOVER];
      end
    end
  end

  always_comb begin
    next_irq = cpu_irq_ctl_reg[slope_adc_pkg::BIT_GLOBAL_EN] & cpu_irq_ctl_reg[slope_adc_pkg::BIT_PERIPH_EN]
      & ((capture_flag & periph_enable_reg[slope_adc_pkg::BIT_CAPTURE])
      | (rollover_flag & periph_enable_reg[slope_adc_pkg::BIT_ROLLOVER]));
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_bus_request;
    req && o_avs_waitrequest;
  endsequence

  sequence s_low_first;
    wr_tmr_low && !high_pending;
  endsequence

  a_bus_answer_next: assert property (s_bus_request |=> !o_avs_waitrequest)
    else $error("bus request not answered after one wait cycle");

  a_timer_counts_up: assert property (running && !tmr_wr |=> ramp_count_timer == $past(ramp_count_timer) + 16'h0001)
    else $error("running timer did not advance by one");

  a_timer_held_stopped: assert property (ramp_reset_ctl && !tmr_wr |=> $stable(ramp_count_timer))
    else $error("timer moved while ramp reset was set");

  a_timer_power_gate: assert property (!powered && !tmr_wr |=> $stable(ramp_count_timer))
    else $error("timer moved while converter powered down");

  a_capture_copies_timer: assert property (cap_strobe && !wr_cap_low && !wr_cap_high
    |=> capture_value == $past(ramp_count_timer) && capture_flag)
    else $error("capture did not copy timer or set flag");

  a_capture_flag_set: assert property (cap_strobe |=> capture_flag ##1 capture_flag || $past(wr_flag))
    else $error("capture flag not set by capture event");

  a_single_capture: assert property (capture_done && !ramp_reset_ctl && !wr_cap_low && !wr_cap_high
    |=> $stable(capture_value))
    else $error("second capture in one conversion cycle");

  a_rollover_sets_flag: assert property (running && !tmr_wr && ramp_count_timer == 16'hFFFF
    |=> rollover_flag && ramp_count_timer == 16'h0000 ##1 (ramp_count_timer == 16'h0001 || !$past(running)
    || $past(tmr_wr)))
    else $error("rollover did not set flag or timer stopped");

  a_irq_gating: assert property (##1 o_irq == $past(next_irq))
    else $error("interrupt output does not follow gated flags");

  a_irq_needs_enables: assert property (o_irq |-> $past(cpu_irq_ctl_reg[7]) && $past(cpu_irq_ctl_reg[6]))
    else $error("interrupt raised without global and peripheral enables");

  a_low_first_stalls: assert property (s_low_first |=> !timer_armed && !running)
    else $error("timer armed by low byte written first");

  a_current_off_reset: assert property (ramp_reset_ctl |=> !o_analog.current_enable
    && o_analog.ramp_discharge)
    else $error("current source on during ramp discharge");

endmodule : slope_adc_timer_capture

/* verif/ramp_cmp_model.sv */
// Purpose: Behavioural ramp capacitor, current source and comparator
// Assumes: The ramp rises one step a clock only while current flows
// Notes: A bounce re-raises the output once, to mimic noise at the crossing
`timescale 1ns/1ps
module ramp_cmp_model (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_discharge,
  input wire logic i_current_en,
  input wire logic [15:0] i_trip,
  input wire logic i_bounce,
  output logic o_cmp
);
  logic [15:0] ramp;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ramp <= 16'h0000;
    end else if (i_discharge || !i_current_en) begin
      ramp <= 16'h0000;
    end else if (ramp != 16'hFFFF) begin
      ramp <= ramp + 16'h0001;
    end
  end
  // High while the ramp is below the input, then low for good unless bouncing
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cmp <= 1'b1;
    end else begin
      o_cmp <= (ramp < i_trip) || (i_bounce && ramp >= i_trip + 16'h14 && ramp < i_trip + 16'h1C);
    end
  end
endmodule : ramp_cmp_model

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the slope converter timer and capture block
// Assumes: One wait cycle per bus access, as the slave answers
// Notes: The second conversion honours the full discharge hold, so the run is long
`timescale 1ns/1ps
module tb_top;
  localparam int HOLD = slope_adc_pkg::RAMP_DISCHARGE_CYC;
  localparam logic [7:0] TL = slope_adc_pkg::IDX_TIMER_LOW;
  localparam logic [7:0] TH = slope_adc_pkg::IDX_TIMER_HIGH;
  localparam logic [7:0] CL = slope_adc_pkg::IDX_CAPTURE_LOW;
  localparam logic [7:0] FLG = slope_adc_pkg::IDX_PERIPH_FLAG;
  localparam logic [7:0] C0 = slope_adc_pkg::IDX_CONV_CTL0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  slope_adc_pkg::avmm_req_type avs = '0;
  slope_adc_pkg::analog_ctl_type ana;
  logic [31:0] rdata;
  logic wait_rq;
  logic cmp;
  logic irq;
  logic [15:0] trip = 16'hFFFF;
  logic [31:0] seed = 32'hAE11;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] pre, cap, t1, t2;
  logic [7:0] b, cs;
  // Columns: cpu irq control, enables, flags, expected request
  logic [27:0] tbl [0:8] = '{28'h0003030, 28'hC003031, 28'h8003030, 28'h4003030, 28'hC002010,
                             28'hC001011, 28'hC002021, 28'hC001020, 28'hC003000};

  always #2 clk = ~clk;

  slope_adc_timer_capture u_dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_rq), .i_ramp_cmp(cmp), .o_analog(ana), .o_irq(irq));
  ramp_cmp_model u_ramp (.i_ref_clk(clk), .i_reset_n(rst_n), .i_discharge(ana.ramp_discharge),
    .i_current_en(ana.current_enable), .i_trip(trip), .i_bounce(1'b1), .o_cmp(cmp));

  task automatic close_out;
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic rnd(output logic [7:0] v);
    seed = lfsr(seed);
    v = seed[7:0];
  endtask : rnd

  // Request held until waitrequest is seen low at an edge, then released for one cycle
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    avs.write <= wr;
    avs.read <= !wr;
    avs.address <= {idx, 2'b00};
    avs.writedata <= {24'h000000, wd};
    avs.byteenable <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 100);
    if (n >= 100) miscompares++;
    rd = rdata[7:0];
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk({8'h00, x}, {8'h00, e});
  endtask : rdc

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(TL, 8'h00);
    rdc(TH, 8'h00);
    rdc(C0, 8'h02);
    rdc(slope_adc_pkg::IDX_SLEEP_CTL, 8'h21);
    rdc(8'h40, 8'h00);
    chk({15'h0000, ana.ramp_discharge}, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      rdc(CL + 8'(i), 8'h00);
      rnd(b);
      wr(CL + 8'(i), b);
      rdc(CL + 8'(i), b);
    end
    wr(slope_adc_pkg::IDX_SLEEP_CTL, 8'h00);
    rnd(cs);
    cs = {cs[7:5], 1'b1, 4'h0};
    wr(slope_adc_pkg::IDX_CONV_CTL1, cs);
    @(posedge clk);
    chk({12'h000, ana.current_sel}, {12'h000, cs[7:4]});
    wr(slope_adc_pkg::IDX_PERIPH_ENABLE, 8'h03);
    wr(slope_adc_pkg::IDX_CPU_IRQ_CTL, 8'h00);
    // Low byte first: the timer must stay still through a whole run
    wr(TL, 8'h55);
    wr(TH, 8'h12);
    // Ramp has sat discharged since power-up; a full hold here would double the run time
    repeat (64) @(posedge clk);
    wr(C0, 8'h00);
    @(posedge clk);
    chk({15'h0000, ana.current_enable}, 16'h0001);
    repeat (40) @(posedge clk);
    wr(C0, 8'h02);
    @(posedge clk);
    chk({15'h0000, ana.current_enable}, 16'h0000);
    rdc(TL, 8'h55);
    rdc(TH, 8'h12);
    // Preload near the top so the rollover comes before the capture
    rnd(b);
    pre = {8'hFF, b};
    rnd(b);
    trip <= 16'h012C + {10'h000, b[5:0]};
    wr(TH, 8'hFF);
    wr(TL, pre[7:0]);
    rdc(TH, 8'hFF);
    rdc(TL, pre[7:0]);
    wr(FLG, 8'h00);
    repeat (HOLD) @(posedge clk);
    wr(C0, 8'h00);
    b = 8'h00;
    for (int i = 0; i < 200 && b[1] !== 1'b1; i++) bus(1'b0, FLG, 8'h00, b);
    repeat (60) @(posedge clk);
    wr(C0, 8'h02);
    bus(1'b0, CL, 8'h00, cap[7:0]);
    bus(1'b0, CL + 8'h01, 8'h00, cap[15:8]);
    chk({15'h0000, (cap - pre - trip) <= 16'h0008}, 16'h0001);
    rdc(FLG, 8'h03);
    bus(1'b0, TL, 8'h00, t1[7:0]);
    bus(1'b0, TH, 8'h00, t1[15:8]);
    repeat (20) @(posedge clk);
    bus(1'b0, TL, 8'h00, t2[7:0]);
    bus(1'b0, TH, 8'h00, t2[15:8]);
    chk(t2, t1);
    chk({15'h0000, (t1 - cap) >= 16'h0028 && (t1 - cap) <= 16'h00C8}, 16'h0001);
    for (int i = 0; i < 9; i++) begin
      wr(slope_adc_pkg::IDX_CPU_IRQ_CTL, tbl[i][27:20]);
      wr(slope_adc_pkg::IDX_PERIPH_ENABLE, tbl[i][19:12]);
      wr(FLG, tbl[i][11:4]);
      repeat (3) @(posedge clk);
      chk({15'h0000, irq}, {15'h0000, tbl[i][0]});
    end
    close_out();
  end
endmodule : tb_top
